// file: common/adcfg_pkg.sv
package adcfg_pkg;
    // Register offsets on the special-function register port.
    localparam logic [7:0] ACC_CFG_ADDR = 8'hBA;
    localparam logic [7:0] CONV_CFG_ADDR = 8'hBC;
    localparam logic [7:0] RESULT_LOW_ADDR = 8'hBE;
    localparam logic [7:0] RESULT_HIGH_ADDR = 8'hBF;
    // Reset values.
    localparam logic [7:0] CONV_CFG_RESET = 8'hF8;
    localparam logic [7:0] ACC_CFG_RESET = 8'h00;
    localparam logic [15:0] ACC_RESET = 16'h0000;
    // Converter configuration fields.
    localparam int DIV_MSB = 7;
    localparam int DIV_LSB = 3;
    localparam int EIGHT_BIT_POS = 2;
    localparam int DELAY_TRACK_POS = 1;
    localparam int GAIN_POS = 0;
    // Accumulator configuration fields.
    localparam int ACCUM_POS = 6;
    localparam int SJ_MSB = 5;
    localparam int SJ_LSB = 3;
    localparam int RPT_MSB = 2;
    localparam int RPT_LSB = 0;
    localparam logic [7:0] ACC_CFG_READ_MASK = 8'h3F;
    // Conversion timing in SAR clocks, and the left-justify code.
    localparam logic [3:0] DELAY_TRACK_TICKS = 4'h3;
    localparam logic [3:0] TEN_BIT_TICKS = 4'hA;
    localparam logic [3:0] EIGHT_BIT_TICKS = 4'h8;
    localparam logic [2:0] SJ_LEFT = 3'h4;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_TRACK = 3'b010,
        ST_CONVERT = 3'b100
    } adcfg_state_e;

    function automatic logic [6:0] adcfg_repeat_total(input logic [2:0] code);
        case (code)
            3'h1: adcfg_repeat_total = 7'h04;
            3'h2: adcfg_repeat_total = 7'h08;
            3'h3: adcfg_repeat_total = 7'h10;
            3'h4: adcfg_repeat_total = 7'h20;
            3'h5: adcfg_repeat_total = 7'h40;
            default: adcfg_repeat_total = 7'h01;
        endcase
    endfunction : adcfg_repeat_total

    function automatic logic [15:0] adcfg_format(input logic [15:0] acc, input logic [2:0] sj);
        case (sj)
            3'h0: adcfg_format = acc;
            3'h1: adcfg_format = acc >> 1;
            3'h2: adcfg_format = acc >> 2;
            3'h3: adcfg_format = acc >> 3;
            SJ_LEFT: adcfg_format = {acc[9:0], 6'h00};
            default: adcfg_format = acc;
        endcase
    endfunction : adcfg_format
endpackage : adcfg_pkg

// file: rtl/adcfg_accumulator_ctrl.sv
`timescale 1ns/10ps
module adcfg_accumulator_ctrl
    import adcfg_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWriteEn,
    input wire logic sfrReadEn,
    input wire logic [7:0] sfrWriteData,
    output logic [7:0] sfrReadData,
    input wire logic converterEnable,
    input wire logic burstModeEnable,
    input wire logic startConversion,
    input wire logic lpOscClockPin,
    input wire logic [9:0] conversionData,
    output logic sarClockTick,
    output logic tracking,
    output logic converting,
    output logic eightBitMode,
    output logic gainUnity,
    output logic endOfConversion
);
    logic [7:0] convCfgReg, convCfgNext;
    logic [7:0] accCfgReg, accCfgNext;
    logic [15:0] accReg, accNext;
    adcfg_state_e stateReg, stateNext;
    logic [3:0] tickCntReg, tickCntNext;
    logic [6:0] burstCntReg, burstCntNext;
    logic [7:0] readDataReg, readDataNext;
    logic eocReg, eocNext;
    logic trackingReg, convertingReg, eightReg, gainReg;
    logic lpSync1Reg, lpSync2Reg, lpPrevReg;
    logic sourceTick;
    logic sarTick;
    logic finish;
    logic [15:0] sample;
    logic [15:0] formatted;
    logic [3:0] convTicks;
    logic [6:0] burstTotal;

    // The oscillator pin is foreign to this clock; only its synchronised edge is used.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            lpSync1Reg <= 1'b0;
            lpSync2Reg <= 1'b0;
            lpPrevReg <= 1'b0;
        end else begin
            lpSync1Reg <= lpOscClockPin;
            lpSync2Reg <= lpSync1Reg;
            lpPrevReg <= lpSync2Reg;
        end
    end

    assign sourceTick = burstModeEnable ? (lpSync2Reg & ~lpPrevReg) : 1'b1;

    adcfg_sar_divider #(
        .DIV_WIDTH(DIV_MSB - DIV_LSB + 1)
    ) u_divider (
        .clock(clock),
        .resetn(resetn),
        .sourceTick(sourceTick),
        .divider(convCfgReg[DIV_MSB:DIV_LSB]),
        .sarTick(sarTick)
    );

    assign convTicks = convCfgReg[EIGHT_BIT_POS] ? EIGHT_BIT_TICKS : TEN_BIT_TICKS;
    assign burstTotal = adcfg_repeat_total(accCfgReg[RPT_MSB:RPT_LSB]);
    assign finish = (stateReg == ST_CONVERT) && sarTick && (tickCntReg == convTicks - 4'h1);
    assign sample = convCfgReg[EIGHT_BIT_POS] ? {6'h00, conversionData[9:2], 2'b00}
                                              : {6'h00, conversionData};
    assign formatted = adcfg_format(accReg, accCfgReg[SJ_MSB:SJ_LSB]);

    always_comb begin
        convCfgNext = convCfgReg;
        accCfgNext = accCfgReg;
        accNext = accReg;
        stateNext = stateReg;
        tickCntNext = tickCntReg;
        burstCntNext = burstCntReg;
        eocNext = 1'b0;
        readDataNext = readDataReg;
        if (sfrWriteEn) begin
            if (sfrAddr == CONV_CFG_ADDR) begin
                convCfgNext = sfrWriteData;
            end else if (sfrAddr == ACC_CFG_ADDR) begin
                accCfgNext = {1'b0, sfrWriteData[6:0]};
            end else if (sfrAddr == RESULT_LOW_ADDR) begin
                accNext = {accReg[15:8], sfrWriteData};
            end else if (sfrAddr == RESULT_HIGH_ADDR) begin
                accNext = {sfrWriteData, accReg[7:0]};
            end
        end
        if (sfrReadEn) begin
            if (sfrAddr == CONV_CFG_ADDR) begin
                readDataNext = convCfgReg;
            end else if (sfrAddr == ACC_CFG_ADDR) begin
                readDataNext = accCfgReg & ACC_CFG_READ_MASK;
            end else if (sfrAddr == RESULT_LOW_ADDR) begin
                readDataNext = convCfgReg[EIGHT_BIT_POS] ? 8'h00 : formatted[7:0];
            end else if (sfrAddr == RESULT_HIGH_ADDR) begin
                readDataNext = formatted[15:8];
            end else begin
                readDataNext = 8'h00;
            end
        end
        case (stateReg)
            ST_IDLE: begin
                tickCntNext = 4'h0;
                if (startConversion && converterEnable) begin
                    stateNext = convCfgReg[DELAY_TRACK_POS] ? ST_TRACK : ST_CONVERT;
                end
            end
            ST_TRACK: begin
                if (sarTick) begin
                    if (tickCntReg == DELAY_TRACK_TICKS - 4'h1) begin
                        tickCntNext = 4'h0;
                        stateNext = ST_CONVERT;
                    end else begin
                        tickCntNext = tickCntReg + 4'h1;
                    end
                end
            end
            ST_CONVERT: begin
                if (sarTick) begin
                    tickCntNext = tickCntReg + 4'h1;
                end
                // A finishing conversion wins over a software write to the result bytes.
                if (finish) begin
                    tickCntNext = 4'h0;
                    stateNext = ST_IDLE;
                    if (burstModeEnable) begin
                        accNext = (burstCntReg == 7'h00) ? sample : accReg + sample;
                        if (burstCntReg + 7'h01 >= burstTotal) begin
                            burstCntNext = 7'h00;
                            eocNext = 1'b1;
                        end else begin
                            burstCntNext = burstCntReg + 7'h01;
                        end
                    end else begin
                        accNext = accCfgReg[ACCUM_POS] ? accReg + sample : sample;
                        burstCntNext = 7'h00;
                        eocNext = 1'b1;
                    end
                end
            end
            default: begin
                stateNext = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            convCfgReg <= CONV_CFG_RESET;
            accCfgReg <= ACC_CFG_RESET;
            accReg <= ACC_RESET;
            stateReg <= ST_IDLE;
            tickCntReg <= 4'h0;
            burstCntReg <= 7'h00;
            readDataReg <= 8'h00;
            eocReg <= 1'b0;
            trackingReg <= 1'b0;
            convertingReg <= 1'b0;
            eightReg <= 1'b0;
            gainReg <= 1'b0;
        end else begin
            convCfgReg <= convCfgNext;
            accCfgReg <= accCfgNext;
            accReg <= accNext;
            stateReg <= stateNext;
            tickCntReg <= tickCntNext;
            burstCntReg <= burstCntNext;
            readDataReg <= readDataNext;
            eocReg <= eocNext;
            trackingReg <= (stateNext == ST_TRACK);
            convertingReg <= (stateNext == ST_CONVERT);
            eightReg <= convCfgNext[EIGHT_BIT_POS];
            gainReg <= convCfgNext[GAIN_POS];
        end
    end

    assign sfrReadData = readDataReg;
    assign sarClockTick = sarTick;
    assign tracking = trackingReg;
    assign converting = convertingReg;
    assign eightBitMode = eightReg;
    assign gainUnity = gainReg;
    assign endOfConversion = eocReg;

    // Helper: cycles since the last SAR tick, valid only while the divider is undisturbed.
    logic [5:0] gapReg;
    logic gapValidReg;
    always_ff @(posedge clock) begin
        if (!resetn) begin
            gapReg <= 6'h00;
            gapValidReg <= 1'b0;
        end else begin
            gapReg <= sarTick ? 6'h00 : gapReg + 6'h01;
            if ((sfrWriteEn && sfrAddr == CONV_CFG_ADDR) || burstModeEnable) begin
                gapValidReg <= 1'b0;
            end else if (sarTick) begin
                gapValidReg <= 1'b1;
            end
        end
    end

    sequence s_startAccepted;
        stateReg == ST_IDLE && startConversion && converterEnable;
    endsequence
    sequence s_lastTick;
        stateReg == ST_CONVERT && sarTick && tickCntReg == convTicks - 4'h1;
    endsequence

    property p_divPeriod;
        @(posedge clock) disable iff (!resetn)
        sarTick && gapValidReg && !burstModeEnable |-> {1'b0, gapReg} == {2'b00, convCfgReg[DIV_MSB:DIV_LSB]};
    endproperty
    a_divPeriod: assert property (p_divPeriod) else $error("SAR tick period wrong");
    property p_burstSource;
        @(posedge clock) disable iff (!resetn)
        burstModeEnable && !(lpSync2Reg && !lpPrevReg) |=> !sarTick;
    endproperty
    a_burstSource: assert property (p_burstSource) else $error("SAR tick without oscillator edge");
    property p_convLength;
        @(posedge clock) disable iff (!resetn)
        s_lastTick |=> stateReg == ST_IDLE && tickCntReg == 4'h0;
    endproperty
    a_convLength: assert property (p_convLength) else $error("Conversion length wrong");
    property p_noDelay;
        @(posedge clock) disable iff (!resetn)
        s_startAccepted ##0 !convCfgReg[DELAY_TRACK_POS] |=> stateReg == ST_CONVERT && converting;
    endproperty
    a_noDelay: assert property (p_noDelay) else $error("Normal track did not convert at once");
    property p_delayTrack;
        @(posedge clock) disable iff (!resetn)
        stateReg == ST_TRACK && sarTick && tickCntReg == 4'h2 |=> stateReg == ST_CONVERT;
    endproperty
    a_delayTrack: assert property (p_delayTrack) else $error("Delayed track length wrong");
    property p_gain;
        @(posedge clock) disable iff (!resetn)
        sfrWriteEn && sfrAddr == CONV_CFG_ADDR |=> gainUnity == $past(sfrWriteData[GAIN_POS]);
    endproperty
    a_gain: assert property (p_gain) else $error("Gain output mismatch");
    property p_accumulate;
        @(posedge clock) disable iff (!resetn)
        s_lastTick ##0 !burstModeEnable ##0 accCfgReg[ACCUM_POS]
            |=> accReg == $past(accReg) + $past(sample);
    endproperty
    a_accumulate: assert property (p_accumulate) else $error("Accumulation wrong");
    property p_latest;
        @(posedge clock) disable iff (!resetn)
        s_lastTick ##0 !burstModeEnable ##0 !accCfgReg[ACCUM_POS] |=> accReg == $past(sample) && endOfConversion;
    endproperty
    a_latest: assert property (p_latest) else $error("Latest result not kept");
    property p_aeReadsZero;
        @(posedge clock) disable iff (!resetn)
        sfrReadEn && sfrAddr == ACC_CFG_ADDR |=> !sfrReadData[ACCUM_POS] && !sfrReadData[7];
    endproperty
    a_aeReadsZero: assert property (p_aeReadsZero) else $error("Accumulate enable read back");
    property p_lowByteZero;
        @(posedge clock) disable iff (!resetn)
        sfrReadEn && sfrAddr == RESULT_LOW_ADDR && convCfgReg[EIGHT_BIT_POS] |=> sfrReadData == 8'h00;
    endproperty
    a_lowByteZero: assert property (p_lowByteZero) else $error("Low byte not zero in 8-bit mode");
    property p_leftJustify;
        @(posedge clock) disable iff (!resetn)
        sfrReadEn && sfrAddr == RESULT_HIGH_ADDR && accCfgReg[SJ_MSB:SJ_LSB] == SJ_LEFT
            |=> sfrReadData == $past(accReg[9:2]);
    endproperty
    a_leftJustify: assert property (p_leftJustify) else $error("Left justified read wrong");
    property p_burstEoc;
        @(posedge clock) disable iff (!resetn)
        s_lastTick ##0 burstModeEnable ##0 (burstCntReg + 7'h01 < burstTotal) |=> !endOfConversion;
    endproperty
    a_burstEoc: assert property (p_burstEoc) else $error("Early end of burst");
endmodule : adcfg_accumulator_ctrl

// file: rtl/adcfg_sar_divider.sv
`timescale 1ns/10ps
module adcfg_sar_divider
    import adcfg_pkg::*;
#(
    parameter int DIV_WIDTH = 5
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic sourceTick,
    input wire logic [DIV_WIDTH-1:0] divider,
    output logic sarTick
);
    logic [DIV_WIDTH-1:0] countReg;
    logic [DIV_WIDTH-1:0] countNext;
    logic tickReg;
    logic tickNext;

    always_comb begin
        countNext = countReg;
        tickNext = 1'b0;
        if (sourceTick) begin
            if (countReg >= divider) begin
                countNext = '0;
                tickNext = 1'b1;
            end else begin
                countNext = countReg + 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            countReg <= '0;
            tickReg <= 1'b0;
        end else begin
            countReg <= countNext;
            tickReg <= tickNext;
        end
    end

    assign sarTick = tickReg;
endmodule : adcfg_sar_divider

// file: verification/adcfg_core_model.sv
`timescale 1ns/10ps
module adcfg_core_model (
    input wire logic clock,
    input wire logic converting,
    input wire logic [9:0] sampleValue,
    output logic [9:0] conversionData
);
    logic [9:0] idlePattern = 10'h2AA;

    // Outside a conversion the core output is not held, so a stale result must never pass for a fresh one.
    always @(posedge clock) begin
        idlePattern <= ~idlePattern ^ sampleValue;
    end

    assign conversionData = converting ? sampleValue : idlePattern;
endmodule : adcfg_core_model

// file: verification/tb.sv
`timescale 1ns/10ps
module tb;
    import adcfg_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] sfrAddr = 8'h00;
    logic sfrWriteEn = 1'b0;
    logic sfrReadEn = 1'b0;
    logic [7:0] sfrWriteData = 8'h00;
    logic [7:0] sfrReadData;
    logic converterEnable = 1'b0;
    logic burstModeEnable = 1'b0;
    logic startConversion = 1'b0;
    logic lpOscClockPin = 1'b0;
    logic [9:0] conversionData;
    logic [9:0] sampleValue = 10'h000;
    logic sarClockTick, tracking, converting, eightBitMode, gainUnity, endOfConversion;
    logic [1:0] readPipe = 2'b00;
    logic [7:0] expectQ[$];
    int failures = 0;
    int n_compared = 0;

    always #50 clock = ~clock;
    // The oscillator period is chosen unrelated to the system clock.
    always #170 lpOscClockPin = ~lpOscClockPin;

    adcfg_accumulator_ctrl adcfg_accumulator_ctrl_i (.clock(clock), .resetn(resetn), .sfrAddr(sfrAddr),
        .sfrWriteEn(sfrWriteEn), .sfrReadEn(sfrReadEn), .sfrWriteData(sfrWriteData), .sfrReadData(sfrReadData),
        .converterEnable(converterEnable), .burstModeEnable(burstModeEnable), .startConversion(startConversion),
        .lpOscClockPin(lpOscClockPin), .conversionData(conversionData), .sarClockTick(sarClockTick),
        .tracking(tracking), .converting(converting), .eightBitMode(eightBitMode), .gainUnity(gainUnity),
        .endOfConversion(endOfConversion));
    adcfg_core_model adcfg_core_model_i (.clock(clock), .converting(converting), .sampleValue(sampleValue),
        .conversionData(conversionData));

    task automatic stop_test();
        if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic check_read(input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected read data: expected %h seen %h", exp, got);
        end
    endtask : check_read

    // Read data appears one cycle after the strobe edge, so the watcher looks one edge later.
    always @(posedge clock) readPipe <= {readPipe[0], sfrReadEn};
    always @(negedge clock) begin
        if (readPipe[1]) begin
            if (expectQ.size() == 0) check("read queue", 16'h0001, 16'h0000);
            else check_read(expectQ.pop_front(), sfrReadData);
        end
    end

    task automatic sfr_access(input logic [7:0] addr, input logic wr, input logic [7:0] data);
        @(posedge clock);
        #1;
        sfrAddr = addr;
        sfrWriteData = data;
        sfrWriteEn = wr;
        sfrReadEn = ~wr;
        if (!wr) expectQ.push_back(data);
        @(posedge clock);
        #1;
        sfrWriteEn = 1'b0;
        sfrReadEn = 1'b0;
    endtask : sfr_access

    task automatic read_result(input logic [15:0] exp, input logic eight);
        sfr_access(RESULT_HIGH_ADDR, 1'b0, exp[15:8]);
        sfr_access(RESULT_LOW_ADDR, 1'b0, eight ? 8'h00 : exp[7:0]);
    endtask : read_result

    function automatic logic [15:0] shape(input logic [15:0] sum, input int sj);
        if (sj < 4) return sum >> sj;
        if (sj == 4) return {sum[9:0], 6'h00};
        return sum;
    endfunction : shape

    // Start is held for two edges: the second one falls while busy and must be ignored.
    task automatic convert(input logic [9:0] value, input int div, input int ticksExp, input logic eocExp);
        int ticks;
        int lastTick;
        int n;
        logic busySeen;
        ticks = 0;
        lastTick = -1;
        busySeen = 1'b0;
        @(posedge clock);
        #1;
        sampleValue = value;
        startConversion = 1'b1;
        for (n = 0; n < 3000; n++) begin
            @(posedge clock);
            #1;
            if (n == 1) startConversion = 1'b0;
            if (converting === 1'b1 || tracking === 1'b1) begin
                busySeen = 1'b1;
                if (sarClockTick === 1'b1) begin
                    if (div >= 0 && lastTick >= 0) check("tick spacing", 16'(div + 1), 16'(n - lastTick));
                    lastTick = n;
                    ticks++;
                end
            end else if (busySeen && n > 1) break;
        end
        if (n == 3000) begin
            failures++;
            stop_test();
        end
        check("end of conversion", 16'(eocExp), 16'(endOfConversion));
        check("sar ticks", 16'(ticksExp), 16'(ticks));
    endtask : convert

    initial begin
        logic [7:0] cfg;
        logic [9:0] v;
        logic [9:0] stored;
        logic [15:0] sum;
        logic [2:0] idx;
        int div;
        int total;
        void'($urandom(32'h54e600a0));
        repeat (3) @(posedge clock);
        #1;
        resetn = 1'b1;
        sfr_access(CONV_CFG_ADDR, 1'b0, CONV_CFG_RESET);
        sfr_access(ACC_CFG_ADDR, 1'b0, ACC_CFG_RESET);
        sfr_access(8'h55, 1'b0, 8'h00);
        // Repeat count stays zero while burst is off, as software must keep it.
        cfg = (8'($urandom) | 8'hC0) & 8'hF8;
        sfr_access(ACC_CFG_ADDR, 1'b1, cfg);
        sfr_access(ACC_CFG_ADDR, 1'b0, cfg & 8'h3F);
        sfr_access(ACC_CFG_ADDR, 1'b1, 8'h00);
        startConversion = 1'b1;
        @(posedge clock);
        #1;
        startConversion = 1'b0;
        repeat (3) @(posedge clock);
        #1;
        check("disabled start", 16'h0000, 16'({converting, tracking}));
        converterEnable = 1'b1;
        for (int c = 0; c < 8; c++) begin
            idx = 3'(c);
            div = int'($urandom_range(3, 0));
            cfg = {5'(div), idx};
            sfr_access(CONV_CFG_ADDR, 1'b1, cfg);
            sfr_access(CONV_CFG_ADDR, 1'b0, cfg);
            check("eight bit mode", 16'(cfg[2]), 16'(eightBitMode));
            check("gain", 16'(cfg[0]), 16'(gainUnity));
            sfr_access(ACC_CFG_ADDR, 1'b1, {1'b0, idx[0], 6'h00});
            sfr_access(RESULT_HIGH_ADDR, 1'b1, 8'h00);
            sfr_access(RESULT_LOW_ADDR, 1'b1, 8'h00);
            sum = 16'h0000;
            repeat (2) begin
                v = 10'($urandom);
                stored = cfg[2] ? {v[9:2], 2'b00} : v;
                sum = idx[0] ? sum + 16'(stored) : 16'(stored);
                convert(v, div, (cfg[2] ? 8 : 10) + (cfg[1] ? 3 : 0), 1'b1);
            end
            for (int sj = 0; sj < 8; sj++) begin
                sfr_access(ACC_CFG_ADDR, 1'b1, {1'b0, idx[0], 3'(sj), 3'h0});
                read_result(shape(sum, sj), cfg[2]);
            end
        end
        burstModeEnable = 1'b1;
        sfr_access(CONV_CFG_ADDR, 1'b1, 8'h00);
        for (int rpt = 0; rpt < 6; rpt++) begin
            total = (rpt == 0) ? 1 : (2 << rpt);
            sfr_access(ACC_CFG_ADDR, 1'b1, {5'h00, 3'(rpt)});
            sum = 16'h0000;
            for (int i = 0; i < total; i++) begin
                v = 10'($urandom);
                sum = sum + 16'(v);
                convert(v, -1, 10, i == total - 1);
            end
            read_result(sum, 1'b0);
        end
        burstModeEnable = 1'b0;
        sfr_access(ACC_CFG_ADDR, 1'b1, 8'h00);
        // A second reset in mid-run must bring back the reset register values and the gain and eight-bit outputs.
        resetn = 1'b0;
        repeat (3) @(posedge clock);
        #1;
        resetn = 1'b1;
        check("gain after reset", 16'(CONV_CFG_RESET[GAIN_POS]), 16'(gainUnity));
        check("eight bit after reset", 16'(CONV_CFG_RESET[EIGHT_BIT_POS]), 16'(eightBitMode));
        sfr_access(CONV_CFG_ADDR, 1'b0, CONV_CFG_RESET);
        sfr_access(ACC_CFG_ADDR, 1'b0, ACC_CFG_RESET);
        read_result(ACC_RESET, CONV_CFG_RESET[EIGHT_BIT_POS]);
        repeat (4) @(posedge clock);
        check("reads left over", 16'h0000, 16'(expectQ.size()));
        stop_test();
    end
endmodule : tb
